// file: hdl/fifo_pin_mux_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef FIFO_PIN_MUX_CFG_SVH
`define FIFO_PIN_MUX_CFG_SVH

`define ADDR_CONFIG 8'h00
`define ADDR_THR_A_IN 8'h04
`define ADDR_THR_B_IN 8'h08
`define ADDR_THR_A_OUT 8'h0c
`define ADDR_STATUS 8'h10
`define ADDR_MASK 8'h14
`define ADDR_STATE 8'h18

`define CFG_PORT_MODE 2'h0
`define CFG_ENGINE_MODE 2'h2
`define CFG_FIFO_MODE 2'h3
`define CFG_RESET 2'h0

`define LEVEL_W 7
`define THR_RESET 7'h40

`define EV_WAKE 0
`define EV_A_IN_FLAG 1
`define EV_B_IN_FLAG 2
`define EV_A_OUT_FLAG 3
`define EV_W 4

`define SYS_CLK_MHZ 100
`define INT_CLK_MHZ 48
`define INT_DIV (`SYS_CLK_MHZ / `INT_CLK_MHZ)

`endif

// file: hdl/fifo_pin_mux_pkg.sv
// types shared by the pin multiplexer files
package fifo_pin_mux_pkg;
	typedef struct packed {
		logic [3:0] ready;
		logic selA;
		logic selB;
		logic extClk;
		logic clkSel;
		logic wakeN;
		logic [7:0] aBus;
		logic [7:0] bBus;
	} pinSample_type;

	typedef struct packed {
		logic [6:0] aIn;
		logic [6:0] bIn;
		logic [6:0] aOut;
	} fillLevel_type;

	typedef struct packed {
		logic aWrite;
		logic bWrite;
		logic aRead;
		logic bRead;
		logic [7:0] data;
	} fifoStrobe_type;

	typedef enum logic {RUNNING, SUSPENDED} power_type;
endpackage

// file: hdl/pin_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// pins and synchronised copy
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinOut
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_type;

	sync_type state;
	sync_type next_state;

	// first stage feeds only the second stage
	always_comb
	begin
		next_state = state;
		next_state.first = pinIn;
		next_state.second = state.first;
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			state <= '0;
		else
			state <= next_state;
	end

	assign pinOut = state.second;
endmodule

// file: hdl/fifo_interface_pin_mux.sv
// pin multiplexer for the parallel interface control and flag pins
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "fifo_pin_mux_cfg.svh"
module fifo_interface_pin_mux (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq,
	// shared input pins
	input wire logic readyIn2,
	input wire logic readyIn3,
	input wire logic readyIn4,
	input wire logic readyIn5,
	input wire logic fifoPairASelect,
	input wire logic fifoPairBSelect,
	input wire logic externalInterfaceClock,
	input wire logic interfaceClockSelect,
	input wire logic wakeupN,
	// shared output pins
	output logic engineCtrlOut0,
	output logic engineCtrlOut1,
	output logic engineCtrlOut2,
	// fifo data bus pins
	input wire logic [7:0] fifoADataBusIn,
	output logic [7:0] fifoADataBusOut,
	output logic fifoADataBusOe,
	input wire logic [7:0] fifoBDataBusIn,
	output logic [7:0] fifoBDataBusOut,
	output logic fifoBDataBusOe,
	// interface engine side
	input wire logic [2:0] engineCtrl,
	output logic [3:0] engineReady,
	output logic interfaceTick,
	// fifo storage side
	input wire fifo_pin_mux_pkg::fillLevel_type fillLevel,
	input wire logic [7:0] aOutData,
	input wire logic [7:0] bOutData,
	output fifo_pin_mux_pkg::fifoStrobe_type fifoStrobe,
	// processor power
	input wire logic suspendReq,
	output logic suspended,
	output logic oscillatorRun
);
	import fifo_pin_mux_pkg::*;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [1:0] cfg;
		logic [6:0] thrAIn;
		logic [6:0] thrBIn;
		logic [6:0] thrAOut;
		logic [3:0] status;
		logic [3:0] mask;
		power_type power;
		logic [2:0] flags;
		logic [2:0] ctlOut;
		logic aDriveEn;
		logic bDriveEn;
		logic [7:0] aData;
		logic [7:0] bData;
		fifoStrobe_type strobe;
		logic extClkPrev;
		logic wakePrev;
		logic [1:0] divCnt;
		logic tick;
		logic [3:0] ready;
	} mux_type;

	localparam logic [1:0] DIV_LAST = 2'(`INT_DIV - 1);

	mux_type state;
	mux_type next_state;
	pinSample_type pins;

	logic fifoMode;
	logic engineMode;
	logic [2:0] levelHit;
	logic [3:0] events;
	logic busWrite;

	pin_sync #(
		.WIDTH($bits(pinSample_type))
	) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.pinIn({readyIn5, readyIn4, readyIn3, readyIn2, fifoPairASelect,
			fifoPairBSelect, externalInterfaceClock, interfaceClockSelect,
			wakeupN, fifoADataBusIn, fifoBDataBusIn}),
		.pinOut(pins)
	);

	assign fifoMode = (state.cfg == `CFG_FIFO_MODE);
	assign engineMode = (state.cfg == `CFG_ENGINE_MODE);
	assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && state.ack;

	// level compare against software thresholds
	assign levelHit[0] = (fillLevel.aIn >= state.thrAIn);
	assign levelHit[1] = (fillLevel.bIn >= state.thrBIn);
	assign levelHit[2] = (fillLevel.aOut >= state.thrAOut);

	always_comb
	begin
		next_state = state;
		events = '0;

		// interface rate: external clock edge or internal divider
		next_state.extClkPrev = pins.extClk;
		next_state.divCnt = (state.divCnt == DIV_LAST) ? 2'h0 :
			state.divCnt + 2'h1;
		if (pins.clkSel)
			next_state.tick = pins.extClk && !state.extClkPrev;
		else
			next_state.tick = (state.divCnt == DIV_LAST);

		// strobes sampled once per interface tick
		next_state.strobe = '0;
		if (fifoMode && state.tick)
		begin
			next_state.strobe.data = pins.ready[2] ?
				(pins.selA ? pins.aBus : pins.bBus) : 8'h00;
			next_state.strobe.aWrite = pins.ready[2] && pins.selA;
			next_state.strobe.bWrite = pins.ready[2] && pins.selB;
			next_state.strobe.aRead = pins.ready[3] && pins.selA &&
				pins.ready[0];
			next_state.strobe.bRead = pins.ready[3] && pins.selB &&
				pins.ready[1];
		end

		// bus drive follows the output enable pins in fifo mode only
		next_state.aDriveEn = fifoMode && pins.ready[0];
		next_state.bDriveEn = fifoMode && pins.ready[1];
		next_state.aData = aOutData;
		next_state.bData = bOutData;

		// engine sees ready pins only when it owns them
		next_state.ready = engineMode ? pins.ready : 4'h0;

		// flags and output pin selection
		next_state.flags = fifoMode ? levelHit : 3'h0;
		if (engineMode)
			next_state.ctlOut = engineCtrl;
		else if (fifoMode)
			next_state.ctlOut = levelHit;
		else
			next_state.ctlOut = 3'h0;

		// flag rise events
		events[`EV_A_IN_FLAG] = next_state.flags[0] && !state.flags[0];
		events[`EV_B_IN_FLAG] = next_state.flags[1] && !state.flags[1];
		events[`EV_A_OUT_FLAG] = next_state.flags[2] && !state.flags[2];

		// power: wake low holds off suspend, falling edge ends it
		next_state.wakePrev = pins.wakeN;
		case (state.power)
			RUNNING:
			begin
				if (suspendReq && pins.wakeN && state.wakePrev)
					next_state.power = SUSPENDED;
			end
			SUSPENDED:
			begin
				if (state.wakePrev && !pins.wakeN)
				begin
					next_state.power = RUNNING;
					events[`EV_WAKE] = 1'b1;
				end
			end
			default:
				next_state.power = RUNNING;
		endcase

		// wishbone: ack one cycle after request, dropped the next
		next_state.ack = wb_cyc_i && wb_stb_i && !state.ack;
		if (wb_cyc_i && wb_stb_i && !state.ack)
		begin
			case (wb_adr_i)
				`ADDR_CONFIG: next_state.rdata = {30'h0, state.cfg};
				`ADDR_THR_A_IN: next_state.rdata = {25'h0, state.thrAIn};
				`ADDR_THR_B_IN: next_state.rdata = {25'h0, state.thrBIn};
				`ADDR_THR_A_OUT: next_state.rdata = {25'h0, state.thrAOut};
				`ADDR_STATUS: next_state.rdata = {28'h0, state.status};
				`ADDR_MASK: next_state.rdata = {28'h0, state.mask};
				`ADDR_STATE: next_state.rdata = {18'h0, pins.ready,
					pins.selA, pins.selB, pins.wakeN,
					state.power == SUSPENDED, state.ctlOut, state.flags};
				default: next_state.rdata = 32'h0;
			endcase
		end

		// writes land at the ack edge; unmapped writes are dropped
		if (busWrite && wb_sel_i[0])
		begin
			case (wb_adr_i)
				`ADDR_CONFIG: next_state.cfg = wb_dat_i[1:0];
				`ADDR_THR_A_IN: next_state.thrAIn = wb_dat_i[6:0];
				`ADDR_THR_B_IN: next_state.thrBIn = wb_dat_i[6:0];
				`ADDR_THR_A_OUT: next_state.thrAOut = wb_dat_i[6:0];
				`ADDR_MASK: next_state.mask = wb_dat_i[3:0];
				`ADDR_STATUS:
					next_state.status = state.status & ~wb_dat_i[3:0];
				default: next_state.cfg = state.cfg;
			endcase
		end
		// a new event wins over a clear in the same cycle
		next_state.status = next_state.status | events;
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= '0;
			state.cfg <= `CFG_RESET;
			state.thrAIn <= `THR_RESET;
			state.thrBIn <= `THR_RESET;
			state.thrAOut <= `THR_RESET;
			state.power <= RUNNING;
			state.extClkPrev <= 1'b0;
			state.wakePrev <= 1'b1;
		end
		else
			state <= next_state;
	end

	assign wb_ack_o = state.ack;
	assign wb_dat_o = state.rdata;
	assign irq = |(state.status & state.mask);
	assign engineCtrlOut0 = state.ctlOut[0];
	assign engineCtrlOut1 = state.ctlOut[1];
	assign engineCtrlOut2 = state.ctlOut[2];
	assign fifoADataBusOut = state.aData;
	assign fifoADataBusOe = state.aDriveEn;
	assign fifoBDataBusOut = state.bData;
	assign fifoBDataBusOe = state.bDriveEn;
	assign engineReady = state.ready;
	assign interfaceTick = state.tick;
	assign fifoStrobe = state.strobe;
	assign suspended = (state.power == SUSPENDED);
	// oscillator stopped only while suspended
	assign oscillatorRun = (state.power == RUNNING);

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	a_oe_gate_a: assert property (fifoADataBusOe |->
		$past(fifoMode) && $past(pins.ready[0]))
		else $error("A bus driven without enable");
	b_oe_gate_a: assert property (fifoBDataBusOe |->
		$past(fifoMode) && $past(pins.ready[1]))
		else $error("B bus driven without enable");
	write_strobe_a: assert property (fifoStrobe.aWrite |->
		$past(state.tick) && $past(pins.ready[2]) && $past(pins.selA))
		else $error("A write without strobe");
	read_strobe_a: assert property (fifoStrobe.bRead |->
		$past(pins.ready[3]) && $past(pins.selB) && $past(fifoMode))
		else $error("B read without strobe");
	ain_flag_a: assert property (fifoMode && levelHit[0] |=>
		state.flags[0] || !$past(fifoMode))
		else $error("A-in flag missing");
	bin_flag_a: assert property (fifoMode && !levelHit[1] |=>
		!state.flags[1])
		else $error("B-in flag false");
	aout_pin_a: assert property (fifoMode && levelHit[2] |=>
		engineCtrlOut2)
		else $error("A-out flag pin low");
	engine_ctl_a: assert property (engineMode |=>
		{engineCtrlOut2, engineCtrlOut1, engineCtrlOut0} ==
		$past(engineCtrl))
		else $error("engine control not routed");
	engine_only_a: assert property (engineMode |=>
		!fifoADataBusOe && fifoStrobe == '0)
		else $error("fifo use in engine mode");
	wake_irq_a: assert property (suspended && state.wakePrev &&
		!pins.wakeN |=> oscillatorRun && state.status[`EV_WAKE])
		else $error("wake edge ignored");
	no_suspend_a: assert property (!pins.wakeN && !suspended |=>
		!suspended)
		else $error("suspended with wake low");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
		wb_ack_o)
		else $error("bus request not acknowledged");

	// link timing: a missed tick would drop a whole byte
	ext_tick_a: assert property (pins.clkSel && pins.extClk &&
		!state.extClkPrev |=> interfaceTick)
		else $error("link clock edge gave no tick");
	int_tick_a: assert property (!pins.clkSel &&
		!$past(pins.clkSel) && interfaceTick |=> !interfaceTick)
		else $error("internal tick longer than one cycle");
	// pair and mode routing
	pair_sel_a: assert property (fifoStrobe.bWrite |->
		$past(pins.selB) && $past(fifoMode))
		else $error("B write without pair select");
	port_quiet_a: assert property (!fifoMode && !engineMode |=>
		{engineCtrlOut2, engineCtrlOut1, engineCtrlOut0} == 3'h0)
		else $error("output pins active in port mode");
	fifo_pins_a: assert property (fifoMode |=> engineReady == 4'h0)
		else $error("engine ready seen in fifo mode");
	// power and status
	osc_stop_a: assert property (suspended |-> !oscillatorRun)
		else $error("oscillator runs while suspended");
	wake_sticky_a: assert property (state.status[`EV_WAKE] &&
		!(busWrite && wb_adr_i == `ADDR_STATUS) |=>
		state.status[`EV_WAKE])
		else $error("wake status lost");

	c_fifo_write: cover property (fifoStrobe.aWrite && fifoStrobe.bWrite);
	c_fifo_read: cover property (fifoStrobe.bRead && fifoBDataBusOe);
	c_wake: cover property (suspended ##1 !suspended);
	c_irq: cover property (irq && state.status[`EV_A_IN_FLAG]);
	c_int_tick: cover property (!pins.clkSel && interfaceTick);
endmodule

// file: dv/fifo_master_model.sv
// outside master that strobes the slave fifos on the link clock
`timescale 1ns/1ps
module fifo_master_model (
	// strobes and selects
	output logic readyIn2,
	output logic readyIn3,
	output logic readyIn4,
	output logic readyIn5,
	output logic fifoPairASelect,
	output logic fifoPairBSelect,
	// link clock and data lines
	output logic externalInterfaceClock,
	output logic [7:0] fifoADataBusIn,
	output logic [7:0] fifoBDataBusIn
);
	initial
	begin
		{readyIn2, readyIn3, readyIn4, readyIn5} = 4'h0;
		{fifoPairASelect, fifoPairBSelect} = 2'h0;
		externalInterfaceClock = 0;
		fifoADataBusIn = 8'h00;
		fifoBDataBusIn = 8'h00;
	end

	// link clock stands still outside frames
	task frames(input int n, input logic wr, rd, a, b, input logic [7:0] d);
		readyIn4 = wr;
		readyIn5 = rd;
		readyIn2 = rd & a;
		readyIn3 = rd & b;
		fifoPairASelect = a;
		fifoPairBSelect = b;
		fifoADataBusIn = d;
		fifoBDataBusIn = d;
		repeat (n)
		begin
			#80 externalInterfaceClock = 1;
			#80 externalInterfaceClock = 0;
		end
		{readyIn2, readyIn3, readyIn4, readyIn5} = 4'h0;
		// released lines show no stale byte
		fifoADataBusIn = ~d;
		fifoBDataBusIn = ~d;
	endtask
endmodule

// file: dv/testbench.sv
// self-checking bench for the fifo interface pin multiplexer
`timescale 1ns/1ps
`include "fifo_pin_mux_cfg.svh"
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin mismatches++; \
	$display("unexpected at %0t: %h %h", $time, a, b); end end
module testbench;
	import fifo_pin_mux_pkg::*;
	logic sys_clk = 0, nrst = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, seed;
	logic wb_ack_o, irq, engineCtrlOut0, engineCtrlOut1, engineCtrlOut2;
	logic readyIn2, readyIn3, readyIn4, readyIn5, fifoPairASelect;
	logic fifoPairBSelect, externalInterfaceClock, interfaceClockSelect = 1;
	logic wakeupN = 1, suspendReq = 0, suspended, oscillatorRun;
	logic [7:0] fifoADataBusIn, fifoADataBusOut, fifoBDataBusIn;
	logic [7:0] fifoBDataBusOut, aOutData = 8'h00, bOutData = 8'h00, wrData;
	logic fifoADataBusOe, fifoBDataBusOe, interfaceTick, expAOut;
	logic [2:0] engineCtrl = 3'h0;
	logic [3:0] engineReady;
	logic [6:0] thr;
	fillLevel_type fillLevel = '0;
	fifoStrobe_type fifoStrobe;
	int aWr, bWr, aRd, bRd, ticks, testsRun, mismatches, i;

	fifo_master_model i_master (.readyIn2, .readyIn3, .readyIn4, .readyIn5,
		.fifoPairASelect, .fifoPairBSelect, .externalInterfaceClock,
		.fifoADataBusIn, .fifoBDataBusIn);
	fifo_interface_pin_mux i_dut (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq,
		.readyIn2, .readyIn3, .readyIn4, .readyIn5, .fifoPairASelect,
		.fifoPairBSelect, .externalInterfaceClock, .interfaceClockSelect,
		.wakeupN, .engineCtrlOut0, .engineCtrlOut1, .engineCtrlOut2,
		.fifoADataBusIn, .fifoADataBusOut, .fifoADataBusOe, .fifoBDataBusIn,
		.fifoBDataBusOut, .fifoBDataBusOe, .engineCtrl, .engineReady,
		.interfaceTick, .fillLevel, .aOutData, .bOutData, .fifoStrobe,
		.suspendReq, .suspended, .oscillatorRun);

	always #5 sys_clk = ~sys_clk;

	// counted mid-cycle, clear of the edge that launches each pulse
	always @(negedge sys_clk)
	begin
		aWr += (fifoStrobe.aWrite === 1'b1);
		bWr += (fifoStrobe.bWrite === 1'b1);
		aRd += (fifoStrobe.aRead === 1'b1);
		bRd += (fifoStrobe.bRead === 1'b1);
		ticks += (interfaceTick === 1'b1);
		if (fifoStrobe.aWrite === 1'b1)
			wrData = fifoStrobe.data;
	end

	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function logic above(input logic [6:0] l, t);
		return l >= t;
	endfunction

	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		if (n == 20)
			mismatches++;
		rd = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge sys_clk);
	endtask

	task stopTest;
		$display("tests %0d mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		#500000;
		mismatches++;
		stopTest;
	end

	initial
	begin
		seed = 32'h7006;
		cyc(4);
		nrst <= 1;
		cyc(1);
		wb(0, `ADDR_CONFIG, 0);
		`CHK(rd[1:0], `CFG_RESET)
		wb(0, `ADDR_THR_A_OUT, 0);
		`CHK(rd[6:0], `THR_RESET)
		wb(1, 8'h1c, 32'hffffffff);
		wb(0, 8'h1c, 0);
		`CHK(rd, 32'h0)
		`CHK({engineCtrlOut2, engineCtrlOut1, engineCtrlOut0}, 3'h0)
		$display("test reset done");
		wb(1, `ADDR_CONFIG, `CFG_ENGINE_MODE);
		repeat (4)
		begin
			seed = lfsr(seed);
			engineCtrl <= seed[2:0];
			cyc(4);
			`CHK({engineCtrlOut2, engineCtrlOut1, engineCtrlOut0}, seed[2:0])
		end
		aWr = 0;
		bWr = 0;
		aRd = 0;
		bRd = 0;
		fork
			i_master.frames(3, 1, 1, 1, 1, 8'h5a);
			begin
				cyc(30);
				`CHK(engineReady, 4'hf)
				`CHK({fifoADataBusOe, fifoBDataBusOe}, 2'h0)
			end
		join
		`CHK(aWr + bWr + aRd + bRd, 0)
		$display("test engine mode done");
		wb(1, `ADDR_CONFIG, `CFG_FIFO_MODE);
		seed = lfsr(seed);
		aWr = 0;
		bWr = 0;
		i_master.frames(5, 1, 0, 1, 1, seed[7:0]);
		cyc(6);
		`CHK(aWr, 5)
		`CHK(bWr, 5)
		`CHK(wrData, seed[7:0])
		aOutData <= seed[7:0];
		bOutData <= seed[7:0];
		for (i = 0; i < 2; i++)
		begin
			aRd = 0;
			bRd = 0;
			fork
				i_master.frames(4, 0, 1, i == 0, i == 1, 8'h00);
				begin
					cyc(30);
					`CHK(fifoADataBusOe, i == 0)
					`CHK(fifoBDataBusOe, i == 1)
					`CHK(i == 0 ? fifoADataBusOut : fifoBDataBusOut, seed[7:0])
				end
			join
			cyc(6);
			`CHK({fifoADataBusOe, fifoBDataBusOe}, 2'h0)
			`CHK(i == 0 ? aRd : bRd, 4)
		end
		interfaceClockSelect <= 0;
		cyc(4);
		ticks = 0;
		cyc(20);
		`CHK(ticks, 10)
		interfaceClockSelect <= 1;
		$display("test fifo strobes done");
		wb(1, `ADDR_STATUS, 32'hf);
		wb(1, `ADDR_MASK, 0);
		expAOut = 0;
		repeat (4)
		begin
			seed = lfsr(seed);
			thr = seed[6:0] | 7'h1;
			fillLevel <= '0;
			cyc(2);
			wb(1, `ADDR_THR_A_IN, {25'h0, thr});
			wb(1, `ADDR_THR_B_IN, {25'h0, thr});
			wb(1, `ADDR_THR_A_OUT, {25'h0, thr});
			fillLevel <= '{aIn: thr, bIn: thr - 7'h1, aOut: seed[14:8]};
			cyc(6);
			expAOut |= above(seed[14:8], thr);
			`CHK(engineCtrlOut0, above(thr, thr))
			`CHK(engineCtrlOut1, above(thr - 7'h1, thr))
			`CHK(engineCtrlOut2, above(seed[14:8], thr))
		end
		`CHK(irq, 1'b0)
		wb(0, `ADDR_STATUS, 0);
		`CHK(rd[3:0], {expAOut, 1'b0, 1'b1, 1'b0})
		wb(1, `ADDR_MASK, 32'h2);
		`CHK(irq, 1'b1)
		wb(1, `ADDR_STATUS, 32'h2);
		wb(0, `ADDR_STATUS, 0);
		`CHK({rd[1], irq}, 2'h0)
		wb(1, `ADDR_MASK, 32'h1);
		$display("test level flags done");
		wakeupN <= 0;
		cyc(4);
		suspendReq <= 1;
		cyc(10);
		`CHK(suspended, 1'b0)
		wakeupN <= 1;
		cyc(8);
		`CHK({suspended, oscillatorRun, irq}, 3'b100)
		wakeupN <= 0;
		cyc(5);
		`CHK({suspended, oscillatorRun, irq}, 3'b011)
		suspendReq <= 0;
		$display("test wake done");
		stopTest;
	end
endmodule
